// >>> asram_map.svh
// Timing constants and pin-level figures for the async SRAM host controller.
// Assumes a 25 MHz system clock; included by the package and by asram_host.
`ifndef ASRAM_MAP_SVH
`define ASRAM_MAP_SVH
`define ASRAM_CLK_NS 40
`define ASRAM_ADDR_W 17
`define ASRAM_DATA_W 8
`define ASRAM_T_ACCESS_NS 55
`define ASRAM_T_WPULSE_NS 45
`define ASRAM_T_FLOAT_NS 20
`define ASRAM_T_HOLD_NS 0
`define ASRAM_CYC_ACCESS ((`ASRAM_T_ACCESS_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_CYC_WPULSE ((`ASRAM_T_WPULSE_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_CYC_FLOAT ((`ASRAM_T_FLOAT_NS + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`define ASRAM_CYC_HOLD 1
`endif

// >>> asram_pkg.sv
// Types shared by the async SRAM host controller.
// Assumes asram_map.svh is on the include path.
`include "asram_map.svh"
package asram_pkg;
	typedef struct packed {
		logic [`ASRAM_ADDR_W-1:0] addr;
		logic [`ASRAM_DATA_W-1:0] wdata;
		logic write;
	} asram_req_t;
	typedef struct packed {
		logic cs_low_n;
		logic cs_high;
		logic oe_n;
		logic we_n;
	} asram_ctl_t;
	typedef enum logic [2:0] {
		ASRAM_IDLE,
		ASRAM_RD_WAIT,
		ASRAM_WR_SETUP,
		ASRAM_WR_PULSE,
		ASRAM_WR_HOLD,
		ASRAM_TURN
	} asram_state_t;
endpackage

// >>> asram_tmr.sv
// Down-counter giving a one-cycle done pulse after a loaded cycle count.
// Assumes a single clock; load and done are synchronous.
`timescale 1ns/1ns
module asram_tmr #(
	parameter int CW = 4
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic load, // Start count
	input wire logic [CW-1:0] cycles, // Cycles to wait, at least one
	output logic done // Pulse when count expires
);
	logic [CW-1:0] cnt_q, cnt_d;
	logic run_q, run_d;
	logic done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = cycles - CW'(1);
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == '0) begin
				run_d = 1'b0;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q - CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule

// >>> asram_host.sv
// Host controller for a 128K x 8 asynchronous static memory.
// Assumes the memory pins are wired directly; data_io is resolved outside
// from data_out and data_oe_n. Inputs are synchronous to clk.
`timescale 1ns/1ns
`include "asram_map.svh"
module asram_host
	import asram_pkg::*;
#(
	parameter int AW = `ASRAM_ADDR_W,
	parameter int DW = `ASRAM_DATA_W
) (
	input wire logic clk, // System clock, 25 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic req_valid, // User request present
	input wire asram_req_t req, // Address, write data, direction
	output logic req_ready, // Pulses the cycle after a request is taken
	output logic rd_valid, // Read data pulse
	output logic [DW-1:0] rd_data, // Read data
	output logic [AW-1:0] addr_lines, // Memory address
	output asram_ctl_t ctl, // Selects and strobes
	input wire logic [DW-1:0] data_in, // Data pins, input side
	output logic [DW-1:0] data_out, // Data pins, output side
	output logic data_oe_n // Low while host drives data pins
);
	localparam int CW = 4;
	localparam logic [CW-1:0] C_ACC = CW'(`ASRAM_CYC_ACCESS);
	localparam logic [CW-1:0] C_WP = CW'(`ASRAM_CYC_WPULSE);
	localparam logic [CW-1:0] C_FL = CW'(`ASRAM_CYC_FLOAT);
	localparam logic [CW-1:0] C_HD = CW'(`ASRAM_CYC_HOLD);

	asram_state_t st_q, st_d;
	logic [AW-1:0] addr_q, addr_d;
	logic [DW-1:0] wd_q, wd_d, rdat_q, rdat_d;
	logic rdv_q, rdv_d, rdy_q, rdy_d, oen_q, oen_d;
	asram_ctl_t ctl_q, ctl_d;
	logic tmr_load;
	logic [CW-1:0] tmr_cyc;
	logic tmr_done;

	asram_tmr #(.CW(CW)) u_tmr (
		.clk(clk),
		.nrst(nrst),
		.load(tmr_load),
		.cycles(tmr_cyc),
		.done(tmr_done)
	);

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		wd_d = wd_q;
		rdat_d = rdat_q;
		rdv_d = 1'b0;
		rdy_d = 1'b0;
		oen_d = oen_q;
		ctl_d = ctl_q;
		tmr_load = 1'b0;
		tmr_cyc = C_ACC;
		unique case (st_q)
			ASRAM_IDLE: begin
				// Deselected while idle so address moves never write
				ctl_d = '{cs_low_n: 1'b1, cs_high: 1'b0, oe_n: 1'b1, we_n: 1'b1};
				if (req_valid && !rdy_q) begin
					rdy_d = 1'b1;
					addr_d = req.addr;
					tmr_load = 1'b1;
					if (req.write) begin
						wd_d = req.wdata;
						// Selects first, strobe later: strobe fall starts the write
						ctl_d = '{cs_low_n: 1'b0, cs_high: 1'b1, oe_n: 1'b1, we_n: 1'b1};
						tmr_cyc = C_FL;
						st_d = ASRAM_WR_SETUP;
					end else begin
						ctl_d = '{cs_low_n: 1'b0, cs_high: 1'b1, oe_n: 1'b0, we_n: 1'b1};
						st_d = ASRAM_RD_WAIT;
					end
				end
			end
			ASRAM_RD_WAIT: begin
				// Sample only after full access time; earlier data may be unknown
				if (tmr_done) begin
					rdat_d = data_in;
					rdv_d = 1'b1;
					ctl_d.oe_n = 1'b1;
					tmr_load = 1'b1;
					tmr_cyc = C_FL;
					st_d = ASRAM_TURN;
				end
			end
			ASRAM_WR_SETUP: begin
				if (tmr_done) begin
					ctl_d.we_n = 1'b0;
					oen_d = 1'b0;
					tmr_load = 1'b1;
					tmr_cyc = C_WP;
					st_d = ASRAM_WR_PULSE;
				end
			end
			ASRAM_WR_PULSE: begin
				if (tmr_done) begin
					ctl_d.we_n = 1'b1;
					tmr_load = 1'b1;
					tmr_cyc = C_HD;
					st_d = ASRAM_WR_HOLD;
				end
			end
			ASRAM_WR_HOLD: begin
				if (tmr_done) begin
					oen_d = 1'b1;
					ctl_d = '{cs_low_n: 1'b1, cs_high: 1'b0, oe_n: 1'b1, we_n: 1'b1};
					st_d = ASRAM_IDLE;
				end
			end
			ASRAM_TURN: begin
				// Let the device release the bus before any host drive
				if (tmr_done) begin
					ctl_d = '{cs_low_n: 1'b1, cs_high: 1'b0, oe_n: 1'b1, we_n: 1'b1};
					st_d = ASRAM_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ASRAM_IDLE;
			addr_q <= '0;
			wd_q <= '0;
			rdat_q <= '0;
			rdv_q <= 1'b0;
			rdy_q <= 1'b0;
			oen_q <= 1'b1;
			ctl_q <= '{cs_low_n: 1'b1, cs_high: 1'b0, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			rdat_q <= rdat_d;
			rdv_q <= rdv_d;
			rdy_q <= rdy_d;
			oen_q <= oen_d;
			ctl_q <= ctl_d;
		end
	end

	assign req_ready = rdy_q;
	assign rd_valid = rdv_q;
	assign rd_data = rdat_q;
	assign addr_lines = addr_q;
	assign ctl = ctl_q;
	assign data_out = wd_q;
	assign data_oe_n = oen_q;
endmodule

// >>> asram_host_sva.sv
// Pin-level assertions for the SRAM host.
// Bound to asram_host; sees its ports only.
`timescale 1ns/1ns
module asram_host_sva
	import asram_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic [16:0] addr_lines, // Address
	input wire asram_ctl_t ctl, // Controls
	input wire logic [7:0] data_out, // Write data
	input wire logic data_oe_n // Host drive, active low
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire sel = !ctl.cs_low_n && ctl.cs_high;
	sequence s_pulse;
		(!ctl.we_n)[*3] ##1 ctl.we_n;
	endsequence
	sequence s_held;
		(!data_oe_n && $stable(data_out))[*2];
	endsequence
	property p_addr;
		$changed(addr_lines) |-> ctl.we_n && $past(ctl.we_n);
	endproperty
	property p_start;
		$fell(ctl.we_n) |-> sel && $past(sel) && !data_oe_n;
	endproperty
	property p_pulse;
		$fell(ctl.we_n) |-> s_pulse;
	endproperty
	property p_hold;
		$rose(ctl.we_n) |-> s_held;
	endproperty
	property p_drive;
		!data_oe_n |-> ctl.oe_n && $past(ctl.oe_n);
	endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	a_start: assert property (p_start) else $error("bad write start");
	a_pulse: assert property (p_pulse) else $error("short strobe");
	a_hold: assert property (p_hold) else $error("data not held");
	a_drive: assert property (p_drive) else $error("bus contention");
endmodule
bind asram_host asram_host_sva chk(.clk(clk), .nrst(nrst), .addr_lines(addr_lines),
	.ctl(ctl), .data_out(data_out), .data_oe_n(data_oe_n));

// >>> asram_mem.sv
// Behavioural 128K x 8 static memory with resolved data pins.
// Released lines show the inverse of the last driven value.
`timescale 1ns/1ns
module asram_mem
	import asram_pkg::*;
(
	input wire logic [16:0] addr_lines, // Address
	input wire asram_ctl_t ctl, // Selects and strobes
	input wire logic [7:0] host_d, // Host data
	input wire logic host_oe_n, // Host drives, active low
	output logic [7:0] data_in // Resolved pins
);
	logic [7:0] mem [0:131071];
	logic [7:0] rd_v;
	logic [16:0] a_early;
	logic [16:0] a_late;
	logic [7:0] last;
	logic sel;
	logic wr;
	logic dev;
	assign sel = !ctl.cs_low_n && ctl.cs_high;
	assign wr = sel && !ctl.we_n;
	assign #5 dev = sel && ctl.we_n && !ctl.oe_n;
	assign #5 a_early = addr_lines;
	assign #55 a_late = addr_lines;
	// Unknown from early transition until full access, so early sampling shows up
	assign rd_v = (a_early === a_late) ? mem[a_late] : 8'hxx;
	assign data_in = !host_oe_n ? host_d : dev ? rd_v : ~last;
	always @(host_oe_n, dev, host_d, rd_v)
		if (!host_oe_n)
			last = host_d;
		else if (dev)
			last = rd_v;
	always @(negedge wr) mem[addr_lines] = data_in;
endmodule

// >>> tb_asram_host.sv
// Self-checking bench for the SRAM host.
// Memory model on the far side; writes are read back.
`timescale 1ns/1ns
module tb_asram_host import asram_pkg::*;;
	logic clk = 0, nrst = 0, req_valid = 0, req_ready, rd_valid, data_oe_n;
	asram_req_t req = '0;
	asram_ctl_t ctl;
	logic [7:0] rd_data, data_in, data_out;
	logic [16:0] addr_lines;
	int err_count = 0, compares = 0;
	always #20 clk = ~clk;
	asram_host uut(.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.addr_lines(addr_lines), .ctl(ctl), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n));
	asram_mem mdl(.addr_lines(addr_lines), .ctl(ctl), .host_d(data_out),
		.host_oe_n(data_oe_n), .data_in(data_in));
	task chk(input logic ok);
		compares++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("Error %0t: mismatch", $time);
		end
	endtask
	task op(input logic w, input logic [16:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		req_valid <= 1'h1;
		req <= '{addr: a, wdata: d, write: w};
		i = 0;
		do begin @(negedge clk); i++; end while (req_ready !== 1'h1 && i < 9);
		@(posedge clk);
		req_valid <= 1'h0;
		chk(i < 9);
		if (w)
			repeat (6) @(posedge clk);
		else begin
			i = 0;
			do begin @(negedge clk); i++; end while (rd_valid !== 1'h1 && i < 9);
			chk(i < 9 && rd_data === d);
		end
	endtask
	task t_edges;
		op(1'h1, 17'h00000, 8'ha5);
		op(1'h1, 17'h1ffff, 8'h5a);
		op(1'h0, 17'h00000, 8'ha5);
		op(1'h0, 17'h1ffff, 8'h5a);
		$display("t_edges done");
	endtask
	task t_b2b;
		op(1'h1, 17'h00155, 8'h01);
		op(1'h1, 17'h00156, 8'hfe);
		op(1'h0, 17'h00155, 8'h01);
		op(1'h0, 17'h00156, 8'hfe);
		$display("t_b2b done");
	endtask
	task t_reread;
		op(1'h1, 17'h00155, 8'h3c);
		op(1'h0, 17'h00155, 8'h3c);
		op(1'h0, 17'h00155, 8'h3c);
		$display("t_reread done");
	endtask
	task t_reset;
		op(1'h1, 17'h0abcd, 8'h69);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(negedge clk);
		chk(ctl === 4'hb && data_oe_n === 1'h1 && addr_lines === 17'h00000);
		@(posedge clk);
		nrst <= 1'h1;
		op(1'h0, 17'h0abcd, 8'h69);
		$display("t_reset done");
	endtask
	task give_verdict;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		chk(ctl === 4'hb && data_oe_n === 1'h1);
		t_edges;
		t_b2b;
		t_reread;
		t_reset;
		give_verdict;
	end
	initial begin
		#100000;
		err_count++;
		give_verdict;
	end
endmodule
